// ### core/i2c_rx_pkg.sv
// Constants and types shared by the two-wire slave receive path
package i2c_rx_pkg;
  localparam logic [7:0] DEV_ADDR    = 8'h6c;
  localparam int         BYTE_BITS   = 8;
  localparam int         FIFO_DEPTH  = 4;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_CNT_END = 4'h8;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PROG   = 2'h1;
  localparam logic [1:0] MODE_DEBUG  = 2'h2;
  localparam int         EV_REQ      = 3;
  localparam int         EV_AM       = 2;
  localparam int         EV_STOP     = 1;
  localparam int         EV_OVF      = 0;
  typedef enum logic [2:0] {
    L_IDLE,
    L_ADDR,
    L_AACK,
    L_DATA,
    L_DACK,
    L_SKIP
  } link_state_t;
endpackage

// ### core/i2c_slave_rx.sv
// Two-wire slave receive path with byte FIFO and link clock domain
`timescale 1ns/1ps

// ****************************************
// Byte FIFO
// ****************************************
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;
  assign in_ready  = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      count_r <= count_r + CW'(push) - CW'(pop);
    end
  end
endmodule
// ****************************************
// Slave receive path top
// ****************************************
module i2c_slave_rx
  import i2c_rx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       link_clk,
  input  wire logic       port_pin_zero,
  input  wire logic       port_pin_one_in,
  output logic            port_pin_one_out,
  output logic            port_pin_one_oe,
  input  wire logic       serial_slave_enable,
  input  wire logic [1:0] op_mode,
  input  wire logic       power_down_req,
  input  wire logic       app_dir_pin_zero,
  input  wire logic       app_dir_pin_one,
  input  wire logic       pull_in_cfg_pin_zero,
  input  wire logic       pull_out_cfg_pin_zero,
  input  wire logic       pull_in_cfg_pin_one,
  input  wire logic       pull_out_cfg_pin_one,
  input  wire logic       data_read,
  input  wire logic       clear_address_match,
  input  wire logic       clear_stop,
  input  wire logic       clear_overflow,
  output logic      [7:0] serial_data_reg,
  output logic            rx_byte_full_flag,
  output logic            address_match_flag,
  output logic            stop_flag,
  output logic            overflow_flag,
  output logic            pullup_pin_zero,
  output logic            pullup_pin_one,
  output logic            dir_pin_zero,
  output logic            dir_pin_one,
  output logic            power_down_state,
  output logic            fw_service
);
  // ****************************************
  // Mode and pin control (ref_clk)
  // ****************************************
  logic fw_mode;
  logic pd_nxt;
  logic active_nxt;
  logic active_r;
  assign fw_mode    = (op_mode == MODE_PROG) || (op_mode == MODE_DEBUG);
  assign pd_nxt     = power_down_req & ~fw_mode;
  assign active_nxt = ~pd_nxt & (serial_slave_enable | fw_mode);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      active_r         <= 1'b0;
      power_down_state <= 1'b0;
      fw_service       <= 1'b0;
    end else if (ce) begin
      active_r         <= active_nxt;
      power_down_state <= pd_nxt;
      fw_service       <= fw_mode & ~pd_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dir_pin_zero    <= 1'b0;
      dir_pin_one     <= 1'b0;
      pullup_pin_zero <= 1'b0;
      pullup_pin_one  <= 1'b0;
    end else if (ce) begin
      dir_pin_zero    <= active_nxt ? 1'b0 : app_dir_pin_zero;
      dir_pin_one     <= active_nxt ? 1'b0 : app_dir_pin_one;
      pullup_pin_zero <= (pull_in_cfg_pin_zero & pull_out_cfg_pin_zero)
                         | (fw_mode & ~pd_nxt);
      pullup_pin_one  <= (pull_in_cfg_pin_one & pull_out_cfg_pin_one)
                         | (fw_mode & ~pd_nxt);
    end
  end
  // ****************************************
  // Link domain synchronisers (link_clk)
  // ****************************************
  logic        lrst_m;
  logic        lrst_s;
  logic        lce_m;
  logic        lce_s;
  logic        scl_m;
  logic        scl_s;
  logic        scl_d;
  logic        sda_m;
  logic        sda_s;
  logic        sda_d;
  logic        act_m;
  logic        act_s;
  logic        ack_m;
  logic        ack_s;
  logic        ack_tgl_r;

  always_ff @(posedge link_clk) begin
    lrst_m <= rstn;
    lrst_s <= lrst_m;
    lce_m  <= ce;
    lce_s  <= lce_m;
    scl_m  <= port_pin_zero;
    scl_s  <= scl_m;
    sda_m  <= port_pin_one_in;
    sda_s  <= sda_m;
    act_m  <= active_r;
    act_s  <= act_m;
    ack_m  <= ack_tgl_r;
    ack_s  <= ack_m;
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (lce_s) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  // ****************************************
  // Link protocol engine
  // ****************************************
  link_state_t st_r;
  logic [3:0]  bits_r;
  logic [7:0]  shift_r;
  logic [7:0]  rx_byte_r;
  logic        req_tgl_r;
  logic        am_tgl_r;
  logic        stop_tgl_r;
  logic        ovf_tgl_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        byte_end;
  logic        addr_hit;
  logic        busy;
  logic        run;
  assign run      = lce_s & act_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_end = scl_fall & (bits_r == BIT_CNT_END);
  assign addr_hit = (shift_r == DEV_ADDR);
  assign busy     = (req_tgl_r != ack_s);
  always_ff @(posedge link_clk) begin
    if (!lrst_s || (lce_s && !act_s)) begin
      st_r <= L_IDLE;
    end else if (run) begin
      if (start_c) begin
        st_r <= L_ADDR;
      end else if (stop_c) begin
        st_r <= L_IDLE;
      end else begin
        unique case (st_r)
          L_IDLE, L_SKIP: begin
          end
          L_ADDR: begin
            if (byte_end) begin
              st_r <= addr_hit ? L_AACK : L_SKIP;
            end
          end
          L_AACK, L_DACK: begin
            if (scl_fall) begin
              st_r <= L_DATA;
            end
          end
          L_DATA: begin
            if (byte_end) begin
              st_r <= L_DACK;
            end
          end
        endcase
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!lrst_s) begin
      bits_r  <= BIT_CNT_RST;
      shift_r <= DATA_RST;
    end else if (run) begin
      if (start_c || byte_end) begin
        bits_r <= BIT_CNT_RST;
      end else if (scl_rise && (st_r == L_ADDR || st_r == L_DATA)) begin
        bits_r  <= bits_r + 4'h1;
        shift_r <= {shift_r[6:0], sda_s};
      end
    end
  end
  // Open drain: output level fixed low, enable drives
  always_ff @(posedge link_clk) begin
    if (!lrst_s) begin
      port_pin_one_out <= 1'b0;
      port_pin_one_oe  <= 1'b0;
    end else if (lce_s) begin
      port_pin_one_out <= 1'b0;
      if (!act_s || start_c || stop_c) begin
        port_pin_one_oe <= 1'b0;
      end else if (byte_end && st_r == L_ADDR) begin
        port_pin_one_oe <= addr_hit;
      end else if (byte_end && st_r == L_DATA) begin
        port_pin_one_oe <= 1'b1;
      end else if (scl_fall) begin
        port_pin_one_oe <= 1'b0;
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (!lrst_s) begin
      rx_byte_r  <= DATA_RST;
      req_tgl_r  <= 1'b0;
      am_tgl_r   <= 1'b0;
      stop_tgl_r <= 1'b0;
      ovf_tgl_r  <= 1'b0;
    end else if (run && !start_c && !stop_c) begin
      if (byte_end && st_r == L_ADDR && addr_hit) begin
        am_tgl_r <= ~am_tgl_r;
      end
      if (byte_end && st_r == L_DATA) begin
        if (busy) begin
          ovf_tgl_r <= ~ovf_tgl_r;
        end else begin
          rx_byte_r <= shift_r;
          req_tgl_r <= ~req_tgl_r;
        end
      end
    end else if (run && stop_c) begin
      if (st_r == L_AACK || st_r == L_DATA || st_r == L_DACK) begin
        stop_tgl_r <= ~stop_tgl_r;
      end
    end
  end
  // ****************************************
  // Event crossing into ref_clk
  // ****************************************
  logic [3:0] ev_m;
  logic [3:0] ev_s;
  logic [3:0] ev_d;
  logic [3:0] ev_p;
  logic       pend_r;
  logic       f_in_ready;
  logic       f_out_valid;
  logic [7:0] f_out_data;
  logic       push;
  logic       pop;
  always_ff @(posedge ref_clk) begin
    ev_m <= {req_tgl_r, am_tgl_r, stop_tgl_r, ovf_tgl_r};
    ev_s <= ev_m;
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ev_d <= 4'h0;
    end else if (ce) begin
      ev_d <= ev_s;
    end
  end
  assign ev_p = ce ? (ev_s ^ ev_d) : 4'h0;
  assign push = pend_r & f_in_ready;
  assign pop  = f_out_valid & (~rx_byte_full_flag | data_read);
  // Link byte stays stable until the ack toggle returns
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pend_r    <= 1'b0;
      ack_tgl_r <= 1'b0;
    end else if (ce) begin
      if (ev_p[EV_REQ]) begin
        pend_r <= 1'b1;
      end else if (push) begin
        pend_r    <= 1'b0;
        ack_tgl_r <= ~ack_tgl_r;
      end
    end
  end
  byte_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (pend_r),
    .in_ready  (f_in_ready),
    .in_data   (rx_byte_r),
    .out_valid (f_out_valid),
    .out_ready (~rx_byte_full_flag | data_read),
    .out_data  (f_out_data)
  );
  // ****************************************
  // Data register and flags
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      serial_data_reg   <= DATA_RST;
      rx_byte_full_flag <= 1'b0;
    end else if (ce) begin
      if (pop) begin
        serial_data_reg   <= f_out_data;
        rx_byte_full_flag <= 1'b1;
      end else if (data_read) begin
        rx_byte_full_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      address_match_flag <= 1'b0;
      stop_flag          <= 1'b0;
      overflow_flag      <= 1'b0;
    end else if (ce) begin
      address_match_flag <= ev_p[EV_AM]
                            | (address_match_flag & ~clear_address_match);
      stop_flag          <= ev_p[EV_STOP] | (stop_flag & ~clear_stop);
      overflow_flag      <= ev_p[EV_OVF] | (overflow_flag & ~clear_overflow);
    end
  end

endmodule

// ### verif/i2c_rx_props.sv
// Concurrent checks on the slave receive path ports
`timescale 1ns/1ps
module i2c_rx_props
  import i2c_rx_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       ce,
  input wire logic       link_clk,
  input wire logic       port_pin_zero,
  input wire logic       port_pin_one_out,
  input wire logic       port_pin_one_oe,
  input wire logic       serial_slave_enable,
  input wire logic [1:0] op_mode,
  input wire logic       power_down_req,
  input wire logic       app_dir_pin_zero,
  input wire logic       pull_in_cfg_pin_zero,
  input wire logic       pull_out_cfg_pin_zero,
  input wire logic       data_read,
  input wire logic       clear_address_match,
  input wire logic [7:0] serial_data_reg,
  input wire logic       rx_byte_full_flag,
  input wire logic       address_match_flag,
  input wire logic       pullup_pin_zero,
  input wire logic       dir_pin_zero,
  input wire logic       dir_pin_one,
  input wire logic       power_down_state,
  input wire logic       fw_service
);
  logic live_r;
  always_ff @(posedge ref_clk) begin
    live_r <= rstn && ce;
  end
  // ********
  // Acknowledge slot, pin control and flag checks
  // ********
  sequence scl_low_s;
    (!port_pin_zero && port_pin_one_oe) [*2];
  endsequence
  sequence oe_run_s;
    port_pin_one_oe [*6];
  endsequence
  a_ack_hold: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(port_pin_one_oe) |-> scl_low_s ##1 oe_run_s) else $error("ack slot broken");
  a_ack_active: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(port_pin_one_oe) |-> serial_slave_enable || op_mode == MODE_PROG
    || op_mode == MODE_DEBUG) else $error("ack while inactive");
  a_out_low: assert property (@(posedge link_clk) disable iff (!rstn)
    port_pin_one_out == 1'b0) else $error("data driven high");
  a_pullup_cfg: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(op_mode == MODE_NORMAL) |->
    pullup_pin_zero == $past(pull_in_cfg_pin_zero & pull_out_cfg_pin_zero))
    else $error("pull-up wrong");
  a_pd_refused: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(op_mode == MODE_PROG || op_mode == MODE_DEBUG) |->
    !power_down_state && fw_service && pullup_pin_zero) else $error("fw mode wrong");
  a_pd_grant: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(power_down_req && op_mode == MODE_NORMAL) |->
    power_down_state && dir_pin_zero == $past(app_dir_pin_zero)) else $error("pd wrong");
  a_dir_owned: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(serial_slave_enable && !power_down_req) |->
    !dir_pin_zero && !dir_pin_one) else $error("dir not owned");
  a_full_drop: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $fell(rx_byte_full_flag) |-> $past(data_read)) else $error("full dropped");
  a_data_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(rx_byte_full_flag && !data_read) |-> $stable(serial_data_reg))
    else $error("data changed");
  a_match_sticky: assert property (@(posedge ref_clk) disable iff (!rstn)
    live_r && $past(address_match_flag && !clear_address_match) |-> address_match_flag)
    else $error("match lost");
endmodule

bind i2c_slave_rx i2c_rx_props i_i2c_rx_props (
  .ref_clk, .rstn, .ce, .link_clk, .port_pin_zero, .port_pin_one_out, .port_pin_one_oe,
  .serial_slave_enable, .op_mode, .power_down_req, .app_dir_pin_zero,
  .pull_in_cfg_pin_zero, .pull_out_cfg_pin_zero, .data_read, .clear_address_match,
  .serial_data_reg, .rx_byte_full_flag, .address_match_flag, .pullup_pin_zero,
  .dir_pin_zero, .dir_pin_one, .power_down_state, .fw_service
);

// ### verif/i2c_bus_master.sv
// Behavioural two-wire bus master
`timescale 1ns/1ps
module i2c_bus_master #(
  parameter int H = 75
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start: data falls while clock high
  task automatic frame_start();
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H sda_low = 1'b1;
    #H scl = 1'b0;
    #H;
  endtask
  // Eight bits first, ninth clock samples the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #H scl = 1'b1;
      #(2 * H) scl = 1'b0;
      #H;
    end
    sda_low = 1'b0;
    #H scl = 1'b1;
    #H ack = ~sda;
    #H scl = 1'b0;
    #H;
  endtask
  // Stop: data rises while clock high
  task automatic frame_stop();
    sda_low = 1'b1;
    #H scl = 1'b1;
    #H sda_low = 1'b0;
    #H;
  endtask
endmodule

// ### verif/i2c_slave_rx_tb.sv
// Self-checking bench for the two-wire slave receive path
`timescale 1ns/1ps
module i2c_slave_rx_tb;
  import i2c_rx_pkg::*;
  logic       ref_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       ce_in = 1'b1;
  logic       en = 1'b0;
  logic [1:0] mode = MODE_NORMAL;
  logic       pd = 1'b0;
  logic [1:0] adir = 2'h0;
  logic [3:0] pcfg = 4'h0;
  logic       rd = 1'b0;
  logic [2:0] clr = 3'h0;
  logic       scl, m_low, oe, out1, ack;
  logic       full, am, stp, ovf, pu0, pu1, dir0, dir1, pds, fw;
  logic [7:0] dreg;
  wire  logic sda;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;

  always #2.5 ref_clk = ~ref_clk;
  initial begin
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end
  assign sda = ~(m_low | (oe & ~out1));

  i2c_slave_rx i_i2c_slave_rx (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce_in), .link_clk(link_clk),
    .port_pin_zero(scl), .port_pin_one_in(sda), .port_pin_one_out(out1),
    .port_pin_one_oe(oe), .serial_slave_enable(en), .op_mode(mode),
    .power_down_req(pd), .app_dir_pin_zero(adir[0]), .app_dir_pin_one(adir[1]),
    .pull_in_cfg_pin_zero(pcfg[0]), .pull_out_cfg_pin_zero(pcfg[1]),
    .pull_in_cfg_pin_one(pcfg[2]), .pull_out_cfg_pin_one(pcfg[3]), .data_read(rd),
    .clear_address_match(clr[0]), .clear_stop(clr[1]), .clear_overflow(clr[2]),
    .serial_data_reg(dreg), .rx_byte_full_flag(full), .address_match_flag(am),
    .stop_flag(stp), .overflow_flag(ovf), .pullup_pin_zero(pu0),
    .pullup_pin_one(pu1), .dir_pin_zero(dir0), .dir_pin_one(dir1),
    .power_down_state(pds), .fw_service(fw)
  );
  i2c_bus_master i_i2c_bus_master (.scl(scl), .sda_low(m_low), .sda(sda));

  task automatic report_and_stop();
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    i_i2c_bus_master.send_byte(b, ack);
    chk1(ack, exp);
    step(1);
  endtask
  task automatic rd_byte(input logic [7:0] exp);
    int k;
    k = 0;
    while (full !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    chk1(full, 1'b1);
    chk8(dreg, exp);
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    step(1);
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    step(13);
    chk8(dreg, DATA_RST);
    chk1(full, 1'b0);
    rstn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      pcfg = i[3:0];
      step(2);
      chk1(pu0, pcfg[0] & pcfg[1]);
      chk1(pu1, pcfg[2] & pcfg[3]);
    end
    pcfg = 4'h0;
    adir = 2'h3;
    step(2);
    chk1(dir0, 1'b1);
    ce_in = 1'b0;
    pcfg = 4'h3;
    step(2);
    chk1(pu0, 1'b0);
    ce_in = 1'b1;
    step(2);
    chk1(pu0, 1'b1);
    pcfg = 4'h0;
    for (int m = 0; m < 3; m++) begin
      mode = m[1:0];
      pd = 1'b1;
      step(2);
      chk1(pds, m == 0);
      chk1(fw, m != 0);
      chk1(pu1, m != 0);
      if (m == 0) chk1(dir1, 1'b1);
    end
    pd = 1'b0;
    mode = MODE_NORMAL;
    step(30);
    i_i2c_bus_master.frame_start();
    put(DEV_ADDR, 1'b0);
    i_i2c_bus_master.frame_stop();
    en = 1'b1;
    step(30);
    chk1(dir0, 1'b0);
    chk1(dir1, 1'b0);
    i_i2c_bus_master.frame_start();
    put(8'h6d, 1'b0);
    put(8'h11, 1'b0);
    chk1(am, 1'b0);
    i_i2c_bus_master.frame_start();
    put(DEV_ADDR, 1'b1);
    chk1(am, 1'b1);
    put(8'ha5, 1'b1);
    put(8'h3c, 1'b1);
    i_i2c_bus_master.frame_stop();
    step(10);
    chk1(stp, 1'b1);
    chk1(ovf, 1'b0);
    rd_byte(8'ha5);
    rd_byte(8'h3c);
    chk1(full, 1'b0);
    clr = 3'h7;
    step(1);
    clr = 3'h0;
    step(1);
    chk1(am, 1'b0);
    chk1(stp, 1'b0);
    i_i2c_bus_master.frame_start();
    put(DEV_ADDR, 1'b1);
    for (int i = 0; i < 7; i++) put(8'h40 + i[7:0], 1'b1);
    i_i2c_bus_master.frame_stop();
    step(10);
    chk1(ovf, 1'b1);
    for (int i = 0; i < 6; i++) rd_byte(8'h40 + i[7:0]);
    chk1(full, 1'b0);
    clr = 3'h4;
    step(1);
    clr = 3'h0;
    step(1);
    chk1(ovf, 1'b0);
    en = 1'b0;
    mode = MODE_PROG;
    step(30);
    i_i2c_bus_master.frame_start();
    put(DEV_ADDR, 1'b1);
    i_i2c_bus_master.frame_stop();
    report_and_stop();
  end
endmodule
